// ===== readout_pkg.sv
// shared constants for the pixel token readout control block
package readout_pkg;

  // ---------------------------------------------------------------
  // matrix geometry
  // ---------------------------------------------------------------
  localparam int NUM_CLUSTERS = 8;
  localparam int PIXELS       = 2760;

  // ---------------------------------------------------------------
  // synchronised pin vector: bit positions
  // ---------------------------------------------------------------
  localparam int PIN_W        = 17;
  localparam int PIN_INIT     = 0;
  localparam int PIN_SHIFT    = 1;
  localparam int PIN_FILL     = 2;
  localparam int PIN_READ     = 3;
  localparam int PIN_WRITE    = 4;
  localparam int PIN_HOLD     = 5;
  localparam int PIN_CLEAR    = 6;
  localparam int PIN_SELFEN   = 7;
  localparam int PIN_MONEN    = 8;
  localparam int PIN_DISC     = 9;

  // ---------------------------------------------------------------
  // register map (byte addresses) and status layout
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK   = 8'h04;
  localparam logic [7:0] ADDR_STATE  = 8'h08;
  localparam int ST_W          = 11;
  localparam int ST_CHAIN_END  = 0;
  localparam int ST_HOLD       = 8;
  localparam int ST_TRIG       = 9;
  localparam int ST_FAST_SHIFT = 10;
  localparam logic [ST_W-1:0] MASK_RESET = 11'h000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SHIFT_PERIOD_NS  = 100;
  localparam int SHIFT_PERIOD_CYC =
    (SHIFT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W            = 8;

endpackage

// ===== pin_sync_if.sv
// synchronised pin levels and edges passed from the sampler to the core
interface pin_sync_if;
  import readout_pkg::*;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;
  modport producer (output lvl, output rise, output fall);
  modport consumer (input lvl, input rise, input fall);
endinterface

// ===== pin_sampler.sv
// two-flop synchronisers and edge detection for all control pins
module pin_sampler
  import readout_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [PIN_W-1:0] pinRaw,
  pin_sync_if.producer          sync
);

  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] stable_q;
  logic [PIN_W-1:0] prev_q;

  // first stage feeds only the second; edges use stages two and three
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q   <= '0;
      stable_q <= '0;
      prev_q   <= '0;
    end else begin
      meta_q   <= pinRaw;
      stable_q <= meta_q;
      prev_q   <= stable_q;
    end
  end

  assign sync.lvl  = stable_q;
  assign sync.rise = stable_q & ~prev_q;
  assign sync.fall = ~stable_q & prev_q;

endmodule // pin_sampler

// ===== token_chain.sv
// token shift register of one cluster, element zero ahead of pixel one
module token_chain
  import readout_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic initLvl,
  input  wire logic shiftFall,
  input  wire logic fillLvl,
  output logic      headToken,
  output logic      tokenPresent,
  output logic      chainEnd
);

  // element 0 is the extra head, 1..PIXELS are the pixels
  logic [PIXELS:0] elem_q;

  // a token leaving the top is dropped, so it leaves no pixel selected
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      elem_q <= '0;
    end else if (initLvl) begin
      elem_q <= {{PIXELS{1'b0}}, 1'b1};
    end else if (shiftFall) begin
      elem_q <= {elem_q[PIXELS-1:0], fillLvl};
    end
  end

  assign headToken    = elem_q[0];
  assign tokenPresent = |elem_q[PIXELS:1];
  assign chainEnd     = elem_q[PIXELS];

  // a lone token at the top leaves no pixel selected after the shift
  property p_drop;
    @(posedge ref_clk) disable iff (srst)
    chainEnd && !(|elem_q[PIXELS-1:0]) && shiftFall && !initLvl
      |=> !tokenPresent;
  endproperty
  a_drop: assert property (p_drop)
    else $error("pixel still selected after token left chain");

endmodule // token_chain

// ===== pixel_token_readout_control.sv
// pixel readout control: token chains, selection, injection, hold, APB
//
// Notes on behaviour
// - eight identical clusters, 2760 chained pixel elements
// - init clears chains and preloads one token
// - shift clock falling edge advances all tokens
// - read connects token pixel to analog bus
// - write rising edge injects into token pixels
// - per-cluster flag when last pixel holds token
// - self-trigger enable adds internal trigger to hold
// - hold strobe puts shapers into peak hold
// - memory clear drops hold, back to tracking
// - active-low cluster trigger output on threshold
// - internal trigger is OR of all clusters
// - same element selects for read and injection
// - token starts ahead of pixel one
// - fill pushes extra token into head element
//
// Our own choices: the APB interface to the registers and the placing of the registers.
module pixel_token_readout_control
  import readout_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    registerInit,
  input  wire logic                    shift_clock,
  input  wire logic                    multi_token_fill,
  input  wire logic                    readSelect,
  input  wire logic                    testWrite,
  input  wire logic                    peak_hold_strobe,
  input  wire logic                    analog_memory_clear,
  input  wire logic                    self_trigger_enable,
  input  wire logic                    trigger_monitor_enable,
  input  wire logic [NUM_CLUSTERS-1:0] clusterOverThreshold,
  output logic      [NUM_CLUSTERS-1:0] busConnect,
  output logic      [NUM_CLUSTERS-1:0] injectPulse,
  output logic      [NUM_CLUSTERS-1:0] chain_end_flag,
  output logic      [NUM_CLUSTERS-1:0] cluster_trigger_n,
  output logic                         peakHold,
  output logic                         irq,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr
);

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  pin_sync_if syncBus ();

  pin_sampler u_sampler (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pinRaw  ({clusterOverThreshold, trigger_monitor_enable,
               self_trigger_enable, analog_memory_clear,
               peak_hold_strobe, testWrite, readSelect,
               multi_token_fill, shift_clock, registerInit}),
    .sync    (syncBus.producer)
  );

  wire                    initLvl   = syncBus.lvl[PIN_INIT];
  wire                    shiftFall = syncBus.fall[PIN_SHIFT];
  wire                    fillLvl   = syncBus.lvl[PIN_FILL];
  wire                    readLvl   = syncBus.lvl[PIN_READ];
  wire                    writeRise = syncBus.rise[PIN_WRITE];
  wire                    holdRise  = syncBus.rise[PIN_HOLD];
  wire                    clearLvl  = syncBus.lvl[PIN_CLEAR];
  wire                    selfEn    = syncBus.lvl[PIN_SELFEN];
  wire                    monEn     = syncBus.lvl[PIN_MONEN];
  wire [NUM_CLUSTERS-1:0] disc      =
    syncBus.lvl[PIN_DISC +: NUM_CLUSTERS];

  // ---------------------------------------------------------------
  // token chains, one per cluster
  // ---------------------------------------------------------------
  logic [NUM_CLUSTERS-1:0] headToken;
  logic [NUM_CLUSTERS-1:0] tokenPresent;
  logic [NUM_CLUSTERS-1:0] chainEnd;

  // all clusters share init, shift and fill
  for (genvar c = 0; c < NUM_CLUSTERS; c++) begin : g_cluster
    token_chain u_chain (
      .ref_clk      (ref_clk),
      .srst         (srst),
      .initLvl      (initLvl),
      .shiftFall    (shiftFall),
      .fillLvl      (fillLvl),
      .headToken    (headToken[c]),
      .tokenPresent (tokenPresent[c]),
      .chainEnd     (chainEnd[c])
    );
  end

  // ---------------------------------------------------------------
  // selection, injection, flags
  // ---------------------------------------------------------------
  logic [NUM_CLUSTERS-1:0] busConnect_q;
  logic [NUM_CLUSTERS-1:0] injectPulse_q;
  logic [NUM_CLUSTERS-1:0] chainEnd_q;
  logic [NUM_CLUSTERS-1:0] trigN_q;

  // bus gating trusts a single token during readout
  wire [NUM_CLUSTERS-1:0] busConnect_d = readLvl ? tokenPresent : '0;
  wire [NUM_CLUSTERS-1:0] inject_d = writeRise ? tokenPresent : '0;
  // monitor off keeps the pads quiet, trigger still works inside
  wire [NUM_CLUSTERS-1:0] trigN_d  = monEn ? ~disc : '1;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busConnect_q  <= '0;
      injectPulse_q <= '0;
      chainEnd_q    <= '0;
      trigN_q       <= '1;
    end else begin
      busConnect_q  <= busConnect_d;
      injectPulse_q <= inject_d;
      chainEnd_q    <= chainEnd;
      trigN_q       <= trigN_d;
    end
  end

  assign busConnect        = busConnect_q;
  assign injectPulse       = injectPulse_q;
  assign chain_end_flag    = chainEnd_q;
  assign cluster_trigger_n = trigN_q;

  // ---------------------------------------------------------------
  // peak and hold
  // ---------------------------------------------------------------
  logic holdActive_q;
  wire  internalTrig = |disc;
  wire  holdStart    = holdRise | (selfEn & internalTrig);
  wire  holdActive_d = clearLvl ? 1'b0 :
                       (holdStart ? 1'b1 : holdActive_q);

  always_ff @(posedge ref_clk) begin
    if (srst) holdActive_q <= 1'b0;
    else      holdActive_q <= holdActive_d;
  end

  assign peakHold = holdActive_q;

  // ---------------------------------------------------------------
  // shift spacing watch
  // ---------------------------------------------------------------
  logic [GAP_W-1:0] gap_q;
  wire  fastShift = shiftFall &
                    (gap_q < GAP_W'(SHIFT_PERIOD_CYC - 1));
  wire  [GAP_W-1:0] gap_d = shiftFall ? '0 :
                    ((&gap_q) ? gap_q : gap_q + 1'b1);

  // saturates so a long idle never looks like a fast edge
  always_ff @(posedge ref_clk) begin
    if (srst || initLvl) gap_q <= '1;
    else                 gap_q <= gap_d;
  end

  // ---------------------------------------------------------------
  // APB slave and interrupt
  // ---------------------------------------------------------------
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [31:0]     prdata_q;

  wire setupPh   = psel & ~penable;
  wire accessPh  = psel & penable;
  wire hitStatus = (paddr == ADDR_STATUS);
  wire hitMask   = (paddr == ADDR_MASK);
  wire hitState  = (paddr == ADDR_STATE);
  wire mapped    = hitStatus | hitMask | hitState;
  wire [NUM_CLUSTERS-1:0] endRise = chainEnd & ~chainEnd_q;
  wire [ST_W-1:0] events = {fastShift, selfEn & internalTrig,
                            holdStart & ~holdActive_q, endRise};
  wire clrStatus = accessPh & ~pwrite & hitStatus;
  // only bits already reported are cleared; later events survive
  wire [ST_W-1:0] status_d =
    (clrStatus ? (status_q & ~prdata_q[ST_W-1:0]) : status_q) | events;
  wire [31:0] stateWord = {22'h000000, holdActive_q, selfEn,
                           tokenPresent};
  wire [31:0] rdMux = hitStatus ? 32'(status_q) :
                      hitMask   ? 32'(mask_q)   :
                      hitState  ? stateWord     : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_q <= '0;
      mask_q   <= MASK_RESET;
      prdata_q <= '0;
    end else begin
      status_q <= status_d;
      if (accessPh && pwrite && hitMask) mask_q <= pwdata[ST_W-1:0];
      if (setupPh) prdata_q <= rdMux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~mapped;
  assign irq     = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_init;
    @(posedge ref_clk) disable iff (srst)
    initLvl |=> headToken[0] && !tokenPresent[0];
  endproperty
  a_init: assert property (p_init)
    else $error("init did not leave a lone head token");

  property p_first_shift;
    @(posedge ref_clk) disable iff (srst)
    shiftFall && !initLvl && !fillLvl && headToken[0] && !tokenPresent[0]
      |=> tokenPresent[0] && !headToken[0];
  endproperty
  a_first_shift: assert property (p_first_shift)
    else $error("first shift did not move token into pixel one");

  property p_fill;
    @(posedge ref_clk) disable iff (srst)
    shiftFall && fillLvl && !initLvl && headToken[1]
      |=> headToken[1] && tokenPresent[1];
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill shift lost or did not add a token");

  property p_idle_hold;
    @(posedge ref_clk) disable iff (srst)
    !shiftFall && !initLvl |=> $stable(tokenPresent) && $stable(headToken);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("token pattern moved without a shift edge");

  property p_bus;
    @(posedge ref_clk) disable iff (srst)
    readLvl && tokenPresent[2] |=> busConnect[2] ##1 (busConnect[2] ||
      !$past(readLvl) || !$past(tokenPresent[2]));
  endproperty
  a_bus: assert property (p_bus)
    else $error("token pixel not connected while read high");

  property p_inject;
    @(posedge ref_clk) disable iff (srst)
    writeRise && tokenPresent[3] |=> injectPulse[3] ##1 !injectPulse[3];
  endproperty
  a_inject: assert property (p_inject)
    else $error("injection pulse missing or too long");

  property p_hold_ext;
    @(posedge ref_clk) disable iff (srst)
    holdRise && !clearLvl |=> peakHold;
  endproperty
  a_hold_ext: assert property (p_hold_ext)
    else $error("hold strobe did not start peak hold");

  property p_hold_self;
    @(posedge ref_clk) disable iff (srst)
    !peakHold && !holdRise && !(selfEn && internalTrig) |=> !peakHold;
  endproperty
  a_hold_self: assert property (p_hold_self)
    else $error("peak hold started without an enabled source");

  property p_clear;
    @(posedge ref_clk) disable iff (srst)
    clearLvl |=> !peakHold;
  endproperty
  a_clear: assert property (p_clear)
    else $error("memory clear did not end peak hold");

  property p_trig;
    @(posedge ref_clk) disable iff (srst)
    monEn && disc[4] |=> !cluster_trigger_n[4];
  endproperty
  a_trig: assert property (p_trig)
    else $error("cluster trigger output stayed high");

  property p_end;
    @(posedge ref_clk) disable iff (srst)
    chainEnd[5] && !chain_end_flag[5]
      |=> chain_end_flag[5] && status_q[ST_CHAIN_END + 5];
  endproperty
  a_end: assert property (p_end)
    else $error("chain end not flagged");

  property p_bus_off;
    @(posedge ref_clk) disable iff (srst)
    !readLvl |=> busConnect == '0;
  endproperty
  a_bus_off: assert property (p_bus_off)
    else $error("analog bus connected while read low");

  property p_inject_quiet;
    @(posedge ref_clk) disable iff (srst)
    !writeRise |=> injectPulse == '0;
  endproperty
  a_inject_quiet: assert property (p_inject_quiet)
    else $error("injection pulse without a write edge");

endmodule // pixel_token_readout_control

// ===== acq_controller_model.sv
// acquisition controller model driving the readout control pins
module acq_controller_model
  import readout_pkg::*;
(
  input  wire logic                    ref_clk,
  output logic                         registerInit,
  output logic                         shift_clock,
  output logic                         multi_token_fill,
  output logic                         readSelect,
  output logic                         testWrite,
  output logic                         peak_hold_strobe,
  output logic                         analog_memory_clear,
  output logic                         self_trigger_enable,
  output logic                         trigger_monitor_enable,
  output logic      [NUM_CLUSTERS-1:0] clusterOverThreshold
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // static levels
  // ----------------------------------------------------------
  // monitor enable stays low unless a debug case raises it
  task automatic setLevels(input logic rd, wr, hold, clr, selfEn, monEn,
                           input logic [NUM_CLUSTERS-1:0] over);
    readSelect             <= rd;
    testWrite              <= wr;
    peak_hold_strobe       <= hold;
    analog_memory_clear    <= clr;
    self_trigger_enable    <= selfEn;
    trigger_monitor_enable <= monEn;
    clusterOverThreshold   <= over;
  endtask

  initial begin
    registerInit     = 1'h0;
    shift_clock      = 1'h0; // idles low between frames
    multi_token_fill = 1'h0; // low except while placing tokens
    setLevels(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
  end

  // ----------------------------------------------------------
  // chain control
  // ----------------------------------------------------------
  task automatic pulseInit();
    registerInit <= 1'h1;
    repeat (4) @(posedge ref_clk);
    registerInit <= 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask

  // fill drops a cycle before the pulse ends, so back to back pulses
  // never write it twice in one step
  task automatic shiftPulse(input logic fill, input int half);
    multi_token_fill <= fill;
    shift_clock      <= 1'h1;
    repeat (half) @(posedge ref_clk);
    shift_clock <= 1'h0;
    repeat (half - 1) @(posedge ref_clk);
    multi_token_fill <= 1'h0;
    @(posedge ref_clk);
  endtask

  // readout uses half of 5 or more, 100 ns per pixel
  task automatic shiftMany(input int n, input int half);
    repeat (n) shiftPulse(1'h0, half);
  endtask
endmodule // acq_controller_model

// ===== pixel_token_readout_control_bench.sv
// self-checking bench for the pixel token readout control block
module pixel_token_readout_control_bench
  import readout_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  localparam logic LO = 1'h0;
  localparam logic HI = 1'h1;
  logic        ref_clk = LO;
  logic        srst    = HI;
  logic        psel = LO, penable = LO, pwrite = LO;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        registerInit, shift_clock, multi_token_fill, readSelect;
  logic        testWrite, peak_hold_strobe, analog_memory_clear;
  logic        self_trigger_enable, trigger_monitor_enable, peakHold, irq;
  logic        pready, pslverr;
  logic [31:0] prdata;
  logic [7:0]  clusterOverThreshold, busConnect, injectPulse;
  logic [7:0]  chain_end_flag, cluster_trigger_n, injLast = 8'h00;
  int          fails = 0, nTests = 0, injCnt = 0;

  typedef struct packed {
    logic       selfEn, monEn, hold;
    logic [7:0] over;
    logic       expPeak;
    logic [7:0] expTrigN;
  } row_t;
  row_t rows [6] = '{
    '{LO, LO, LO, 8'h00, LO, 8'hFF},
    '{LO, HI, LO, 8'h05, LO, 8'hFA},
    '{HI, LO, LO, 8'h80, HI, 8'hFF},
    '{LO, LO, HI, 8'h00, HI, 8'hFF},
    '{HI, HI, HI, 8'h00, HI, 8'hFF},
    '{HI, HI, LO, 8'h01, HI, 8'hFE}
  };

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  pixel_token_readout_control DUT (
    .ref_clk, .srst, .registerInit, .shift_clock, .multi_token_fill,
    .readSelect, .testWrite, .peak_hold_strobe, .analog_memory_clear,
    .self_trigger_enable, .trigger_monitor_enable, .clusterOverThreshold,
    .busConnect, .injectPulse, .chain_end_flag, .cluster_trigger_n,
    .peakHold, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  acq_controller_model ctl (
    .ref_clk, .registerInit, .shift_clock, .multi_token_fill, .readSelect,
    .testWrite, .peak_hold_strobe, .analog_memory_clear,
    .self_trigger_enable, .trigger_monitor_enable, .clusterOverThreshold);

  // one-cycle pulses are easy to miss, so count them as they pass
  always @(posedge ref_clk) begin
    if (injectPulse !== 8'h00) begin
      injCnt  <= injCnt + 1;
      injLast <= injectPulse;
    end
  end

  // ----------------------------------------------------------
  // checks and bus tasks
  // ----------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] got, exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s at %0t: %0h not %0h", what, $time, got, exp);
    end
  endtask
  task automatic checkPin(input logic [31:0] got, exp);
    cmp("pin", got, exp);
  endtask
  task automatic checkReg(input logic [31:0] got, exp);
    cmp("register", got, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apbXfer(input logic wr, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r,
                         output logic err);
    int n;
    n = 0;
    psel    <= HI;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    tick(1);
    penable <= HI;
    do begin
      tick(1);
      n++;
    end while (pready !== HI && n < 20);
    cmp("ready", pready, HI);
    r = prdata;
    err = pslverr;
    psel    <= LO;
    penable <= LO;
    tick(1);
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp,
                       input logic expErr);
    logic [31:0] r;
    logic        e;
    apbXfer(LO, a, 32'h0, r, e);
    checkReg(r, exp);
    checkReg(e, expErr);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apbXfer(HI, a, d, r, e);
  endtask

  task automatic injectOnce(input logic rd);
    int base;
    base = injCnt;
    ctl.setLevels(rd, HI, LO, LO, LO, LO, 8'h00);
    tick(6);
    ctl.setLevels(rd, LO, LO, LO, LO, LO, 8'h00);
    tick(2);
    checkPin(injCnt - base, 1);
    checkPin(injLast, 8'hFF);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    tick(10);
    srst <= LO;
    tick(1);
    checkPin({14'h0, peakHold, irq, busConnect, chain_end_flag}, 32'h0);
    checkPin(cluster_trigger_n, 8'hFF);
    foreach (rows[i]) begin
      ctl.setLevels(LO, LO, rows[i].hold, LO, rows[i].selfEn,
                    rows[i].monEn, rows[i].over);
      tick(8);
      checkPin(peakHold, rows[i].expPeak);
      checkPin(cluster_trigger_n, rows[i].expTrigN);
      ctl.setLevels(LO, LO, LO, HI, LO, LO, 8'h00);
      tick(8);
      ctl.setLevels(LO, LO, LO, LO, LO, LO, 8'h00);
      tick(8);
      checkPin(peakHold, LO);
    end
    checkPin(irq, LO);
    rdReg(ADDR_STATUS, (1 << ST_HOLD) | (1 << ST_TRIG), LO);
    rdReg(ADDR_STATUS, 32'h0, LO);
    rdReg(ADDR_MASK, {21'h0, MASK_RESET}, LO);
    wrReg(ADDR_MASK, 32'hFF);
    rdReg(ADDR_MASK, 32'hFF, LO);
    rdReg(8'h0C, 32'h0, HI);
    // single token through a whole cluster
    ctl.pulseInit();
    rdReg(ADDR_STATE, 32'h0, LO);
    ctl.setLevels(HI, LO, LO, LO, LO, LO, 8'h00);
    ctl.shiftMany(1, 5);
    tick(6);
    checkPin(busConnect, 8'hFF);
    injectOnce(HI);
    ctl.shiftMany(PIXELS - 1, 5);
    tick(6);
    checkPin(chain_end_flag, 8'hFF);
    checkPin(irq, HI);
    rdReg(ADDR_STATUS, 32'hFF, LO);
    checkPin(irq, LO);
    ctl.shiftMany(1, 5);
    tick(6);
    checkPin({chain_end_flag, busConnect}, 16'h0);
    rdReg(ADDR_STATE, 32'h0, LO);
    // two tokens, injected together with read low
    ctl.setLevels(LO, LO, LO, LO, LO, LO, 8'h00);
    ctl.pulseInit();
    ctl.shiftPulse(HI, 5);
    ctl.shiftMany(PIXELS - 1, 5);
    tick(6);
    checkPin(chain_end_flag, 8'hFF);
    injectOnce(LO);
    ctl.shiftMany(1, 5);
    tick(6);
    checkPin(chain_end_flag, 8'hFF);
    ctl.shiftMany(1, 5);
    tick(6);
    checkPin(chain_end_flag, 8'h00);
    rdReg(ADDR_STATUS, 32'hFF, LO);
    // shift clock at 80 ns is flagged but still shifts
    ctl.pulseInit();
    ctl.shiftMany(2, 4);
    tick(6);
    rdReg(ADDR_STATUS, 1 << ST_FAST_SHIFT, LO);
    rdReg(ADDR_STATE, 32'hFF, LO);
    srst <= HI;
    tick(3);
    srst <= LO;
    tick(1);
    rdReg(ADDR_STATE, 32'h0, LO);
    rdReg(ADDR_MASK, 32'h0, LO);
    test_done();
  end

  initial begin
    tick(80000);
    fails++;
    $display("unexpected timeout at %0t", $time);
    test_done();
  end
endmodule // pixel_token_readout_control_bench
